// ===== src/cps_core_regs.sv
`timescale 1ns/1ps
module cps_core_regs (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire cps_pkg::cps_sfr_req_t sfr_req_i,
  input wire cps_pkg::cps_alu_flags_t alu_flags_i,
  input wire cps_pkg::cps_core_cmd_t core_cmd_i,
  input wire logic [2:0] reg_idx_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  output logic [7:0] stack_top_pointer_o,
  output logic [15:0] data_pointer_o,
  output logic [7:0] program_status_word_o,
  output logic [7:0] accumulator_o,
  output logic [7:0] bank_reg_addr_o
);

  typedef struct packed {
    logic [7:0] stack_top_pointer;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic carry_flag;
    logic half_carry_flag;
    logic user_flag_a;
    logic bank_select_high;
    logic bank_select_low;
    logic overflow_flag;
    logic user_flag_b;
    logic parity_flag;
    logic [7:0] accumulator;
    logic [7:0] rdata;
    logic hit;
    logic [7:0] bank_addr;
  } cps_state_t;

  cps_state_t state_q;
  cps_state_t state_d;
  logic [7:0] bank_addr_w;
  logic [7:0] psw_w;
  // register selects decoded once and shared by the write and read paths
  logic sel_stack_w;
  logic sel_data_pointer_lo_w;
  logic sel_data_pointer_hi_w;
  logic sel_psw_w;
  logic sel_acc_w;
  // accumulator value for the next edge and the running xor over it
  logic [7:0] acc_next_w;
  logic [7:0] par_chain_w;

  // bank address from the current (registered) bank bits
  cps_bank_map u_bank_map (
    .bank_i({state_q.bank_select_high, state_q.bank_select_low}),
    .reg_idx_i(reg_idx_i),
    .ram_addr_o(bank_addr_w)
  );

  // address decode; reserved and foreign locations select nothing
  always_comb
  begin
    sel_stack_w = 1'b0;
    sel_data_pointer_lo_w = 1'b0;
    sel_data_pointer_hi_w = 1'b0;
    sel_psw_w = 1'b0;
    sel_acc_w = 1'b0;
    unique case (sfr_req_i.addr)
      cps_pkg::SFR_ADDR_STACK: sel_stack_w = 1'b1;
      cps_pkg::SFR_ADDR_DATA_POINTER_LO: sel_data_pointer_lo_w = 1'b1;
      cps_pkg::SFR_ADDR_DATA_POINTER_HI: sel_data_pointer_hi_w = 1'b1;
      cps_pkg::SFR_ADDR_PSW: sel_psw_w = 1'b1;
      cps_pkg::SFR_ADDR_ACC: sel_acc_w = 1'b1;
      default: ;
    endcase
  end

  // accumulator the next edge will store; an sfr write beats the core load
  always_comb
  begin
    acc_next_w = state_q.accumulator;
    if (core_cmd_i.acc_wr)
    begin
      acc_next_w = core_cmd_i.acc_data;
    end
    if (sfr_req_i.wr && sel_acc_w)
    begin
      acc_next_w = sfr_req_i.wdata;
    end
  end

  // parity of the next accumulator, one xor stage per bit; stored beside the
  // accumulator so the status output is a flop yet never lags the accumulator
  generate
    for (genvar i = 0; i < $bits(acc_next_w); i++)
    begin : g_parity
      if (i == 0)
      begin : g_first
        assign par_chain_w[i] = acc_next_w[i];
      end
      else
      begin : g_rest
        assign par_chain_w[i] = par_chain_w[i - 1] ^ acc_next_w[i];
      end
    end
  endgenerate

  // status word as software reads it; every bit is a flop, positions from the package
  always_comb
  begin
    psw_w = '0;
    psw_w[cps_pkg::PSW_CARRY_BIT] = state_q.carry_flag;
    psw_w[cps_pkg::PSW_HALF_BIT] = state_q.half_carry_flag;
    psw_w[cps_pkg::PSW_USER_A_BIT] = state_q.user_flag_a;
    psw_w[cps_pkg::PSW_BANK_HI_BIT] = state_q.bank_select_high;
    psw_w[cps_pkg::PSW_BANK_LO_BIT] = state_q.bank_select_low;
    psw_w[cps_pkg::PSW_OVF_BIT] = state_q.overflow_flag;
    psw_w[cps_pkg::PSW_USER_B_BIT] = state_q.user_flag_b;
    psw_w[cps_pkg::PSW_PARITY_BIT] = state_q.parity_flag;
  end

  // next state; sfr writes take priority over core updates of the same register
  always_comb
  begin
    state_d = state_q;
    // stack: push pre-increments, pop post-decrements
    if (core_cmd_i.push)
    begin
      state_d.stack_top_pointer = state_q.stack_top_pointer + cps_pkg::STACK_STEP;
    end
    else if (core_cmd_i.pop)
    begin
      state_d.stack_top_pointer = state_q.stack_top_pointer - cps_pkg::STACK_STEP;
    end
    // accumulator and its parity always move together
    state_d.accumulator = acc_next_w;
    state_d.parity_flag = par_chain_w[$bits(acc_next_w) - 1];
    // arithmetic sets or clears all three flags; user flags untouched
    if (alu_flags_i.upd)
    begin
      state_d.carry_flag = alu_flags_i.carry;
      state_d.half_carry_flag = alu_flags_i.half;
      state_d.overflow_flag = alu_flags_i.ovf;
    end
    // software writes come last so they win over push, pop and the alu
    if (sfr_req_i.wr)
    begin
      if (sel_stack_w)
      begin
        state_d.stack_top_pointer = sfr_req_i.wdata;
      end
      if (sel_data_pointer_lo_w)
      begin
        state_d.data_pointer_low = sfr_req_i.wdata;
      end
      if (sel_data_pointer_hi_w)
      begin
        state_d.data_pointer_high = sfr_req_i.wdata;
      end
      if (sel_psw_w)
      begin
        // parity bit ignored on write: it only ever follows the accumulator
        state_d.carry_flag = sfr_req_i.wdata[cps_pkg::PSW_CARRY_BIT];
        state_d.half_carry_flag = sfr_req_i.wdata[cps_pkg::PSW_HALF_BIT];
        state_d.user_flag_a = sfr_req_i.wdata[cps_pkg::PSW_USER_A_BIT];
        state_d.bank_select_high = sfr_req_i.wdata[cps_pkg::PSW_BANK_HI_BIT];
        state_d.bank_select_low = sfr_req_i.wdata[cps_pkg::PSW_BANK_LO_BIT];
        state_d.overflow_flag = sfr_req_i.wdata[cps_pkg::PSW_OVF_BIT];
        state_d.user_flag_b = sfr_req_i.wdata[cps_pkg::PSW_USER_B_BIT];
      end
    end
    // read data registered; unmapped addresses read zero and hit low
    state_d.rdata = '0;
    state_d.hit = 1'b0;
    if (sfr_req_i.rd)
    begin
      state_d.hit = sel_stack_w | sel_data_pointer_lo_w | sel_data_pointer_hi_w | sel_psw_w | sel_acc_w;
      if (sel_stack_w)
      begin
        state_d.rdata = state_q.stack_top_pointer;
      end
      if (sel_data_pointer_lo_w)
      begin
        state_d.rdata = state_q.data_pointer_low;
      end
      if (sel_data_pointer_hi_w)
      begin
        state_d.rdata = state_q.data_pointer_high;
      end
      if (sel_acc_w)
      begin
        state_d.rdata = state_q.accumulator;
      end
      if (sel_psw_w)
      begin
        state_d.rdata = psw_w;
      end
    end
    state_d.bank_addr = bank_addr_w;
  end

  // one register bank for all state
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= '0;
      state_q.stack_top_pointer <= cps_pkg::STACK_RESET;
      state_q.data_pointer_low <= cps_pkg::DATA_POINTER_LO_RESET;
      state_q.data_pointer_high <= cps_pkg::DATA_POINTER_HI_RESET;
      state_q.carry_flag <= cps_pkg::PSW_RESET[cps_pkg::PSW_CARRY_BIT];
      state_q.half_carry_flag <= cps_pkg::PSW_RESET[cps_pkg::PSW_HALF_BIT];
      state_q.user_flag_a <= cps_pkg::PSW_RESET[cps_pkg::PSW_USER_A_BIT];
      state_q.bank_select_high <= cps_pkg::PSW_RESET[cps_pkg::PSW_BANK_HI_BIT];
      state_q.bank_select_low <= cps_pkg::PSW_RESET[cps_pkg::PSW_BANK_LO_BIT];
      state_q.overflow_flag <= cps_pkg::PSW_RESET[cps_pkg::PSW_OVF_BIT];
      state_q.user_flag_b <= cps_pkg::PSW_RESET[cps_pkg::PSW_USER_B_BIT];
      // parity of a cleared accumulator is even
      state_q.parity_flag <= cps_pkg::PSW_RESET[cps_pkg::PSW_PARITY_BIT];
      state_q.accumulator <= cps_pkg::ACC_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // outputs straight from flops; the status word is only a regrouping of flops
  assign sfr_rdata_o = state_q.rdata;
  assign sfr_hit_o = state_q.hit;
  assign stack_top_pointer_o = state_q.stack_top_pointer;
  assign data_pointer_o = {state_q.data_pointer_high, state_q.data_pointer_low};
  assign program_status_word_o = psw_w;
  assign accumulator_o = state_q.accumulator;
  assign bank_reg_addr_o = state_q.bank_addr;

endmodule : cps_core_regs

// ===== common/cps_pkg.sv
package cps_pkg;

  // special function register addresses
  localparam logic [7:0] SFR_ADDR_STACK = 8'h81;
  localparam logic [7:0] SFR_ADDR_DATA_POINTER_LO = 8'h82;
  localparam logic [7:0] SFR_ADDR_DATA_POINTER_HI = 8'h83;
  localparam logic [7:0] SFR_ADDR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ADDR_ACC = 8'he0;

  // reset values
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [7:0] DATA_POINTER_LO_RESET = 8'h00;
  localparam logic [7:0] DATA_POINTER_HI_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;

  // status word field positions
  localparam int PSW_CARRY_BIT = 7;
  localparam int PSW_HALF_BIT = 6;
  localparam int PSW_USER_A_BIT = 5;
  localparam int PSW_BANK_HI_BIT = 4;
  localparam int PSW_BANK_LO_BIT = 3;
  localparam int PSW_OVF_BIT = 2;
  localparam int PSW_USER_B_BIT = 1;
  localparam int PSW_PARITY_BIT = 0;

  // bank base is bank code times eight bytes
  localparam int BANK_SHIFT = 3;
  localparam logic [7:0] STACK_STEP = 8'h01;

  // arithmetic flag update from the alu
  typedef struct packed {
    logic upd;
    logic carry;
    logic half;
    logic ovf;
  } cps_alu_flags_t;

  // sfr access port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cps_sfr_req_t;

  // core side pointer commands and accumulator load
  typedef struct packed {
    logic push;
    logic pop;
    logic acc_wr;
    logic [7:0] acc_data;
  } cps_core_cmd_t;

endpackage : cps_pkg

// ===== src/cps_bank_map.sv
`timescale 1ns/1ps
// maps a working register index onto internal ram by bank
module cps_bank_map (
  input wire logic [1:0] bank_i,
  input wire logic [2:0] reg_idx_i,
  output logic [7:0] ram_addr_o
);

  // base = bank * 8, registers ascend from the base
  always_comb
  begin
    ram_addr_o = {3'h0, bank_i, reg_idx_i};
  end

endmodule : cps_bank_map

// ===== verif/cps_core_regs_sva.sv
`timescale 1ns/1ps
module cps_core_regs_sva (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire cps_pkg::cps_sfr_req_t sfr_req_i,
  input wire cps_pkg::cps_alu_flags_t alu_flags_i,
  input wire cps_pkg::cps_core_cmd_t core_cmd_i,
  input wire logic [2:0] reg_idx_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  input wire logic [7:0] stack_top_pointer_o,
  input wire logic [15:0] data_pointer_o,
  input wire logic [7:0] program_status_word_o,
  input wire logic [7:0] accumulator_o,
  input wire logic [7:0] bank_reg_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // a status word write wins over the alu, so flag checks step aside
  logic psw_wr;
  assign psw_wr = sfr_req_i.wr && sfr_req_i.addr == 8'hd0;
  rst_val_a: assert property ($fell(rst_i) |->
    stack_top_pointer_o == 8'h07 && accumulator_o == 8'h00)
    else $error("reset value wrong");
  push_inc_a: assert property (core_cmd_i.push && !sfr_req_i.wr |=>
    stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01)
    else $error("push did not step");
  data_pointer_lo_a: assert property (sfr_req_i.wr && sfr_req_i.addr == 8'h82 |=>
    data_pointer_o[7:0] == $past(sfr_req_i.wdata))
    else $error("low byte wrong");
  data_pointer_hi_a: assert property (sfr_req_i.wr && sfr_req_i.addr == 8'h83 |=>
    data_pointer_o[15:8] == $past(sfr_req_i.wdata) && $stable(data_pointer_o[7:0]))
    else $error("high byte wrong");
  alu_flags_a: assert property (alu_flags_i.upd && !psw_wr |=>
    {program_status_word_o[7:6], program_status_word_o[2]} ==
    $past({alu_flags_i.carry, alu_flags_i.half, alu_flags_i.ovf}))
    else $error("flags not loaded");
  parity_bit_a: assert property (program_status_word_o[0] == ^accumulator_o)
    else $error("parity wrong");
  acc_write_a: assert property (sfr_req_i.wr && sfr_req_i.addr == 8'he0 |=>
    accumulator_o == $past(sfr_req_i.wdata))
    else $error("accumulator write lost");
  bank_map_a: assert property (1'b1 |=> bank_reg_addr_o == {3'b000, $past(program_status_word_o[4:3]), $past(reg_idx_i)})
    else $error("bank address wrong");
  user_flag_a: assert property (!psw_wr |=> $stable(program_status_word_o[5]) && $stable(program_status_word_o[1]))
    else $error("user flag moved");
endmodule : cps_core_regs_sva
bind cps_core_regs cps_core_regs_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i),
  .alu_flags_i(alu_flags_i), .core_cmd_i(core_cmd_i), .reg_idx_i(reg_idx_i), .sfr_rdata_o(sfr_rdata_o),
  .sfr_hit_o(sfr_hit_o), .stack_top_pointer_o(stack_top_pointer_o), .data_pointer_o(data_pointer_o),
  .program_status_word_o(program_status_word_o), .accumulator_o(accumulator_o), .bank_reg_addr_o(bank_reg_addr_o));

// ===== verif/cps_cpu_model.sv
`timescale 1ns/1ps
module cps_cpu_model (
  input wire logic core_clk_i,
  input wire logic [15:0] op_i,
  output cps_pkg::cps_alu_flags_t alu_flags_o,
  output cps_pkg::cps_core_cmd_t core_cmd_o
);
  logic [8:0] sum;
  logic [4:0] nib;
  // alu adds the low byte and a byte holding the nibble op_i[11:8] in both halves
  assign sum = {1'b0, op_i[7:0]} + {1'b0, op_i[11:8], op_i[11:8]};
  assign nib = {1'b0, op_i[3:0]} + {1'b0, op_i[11:8]};
  // launched after the edge so the core takes it one cycle later; unknown
  // before the first edge, which always falls inside reset
  always @(posedge core_clk_i)
  begin
    alu_flags_o <= '{upd: op_i[15], carry: sum[8], half: nib[4], ovf: sum[8]};
    core_cmd_o <= '{push: op_i[12], pop: op_i[13], acc_wr: op_i[14], acc_data: op_i[7:0]};
  end
endmodule : cps_cpu_model

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk_i, rst_i, sfr_hit_o;
  cps_pkg::cps_sfr_req_t sfr_req_i;
  cps_pkg::cps_alu_flags_t alu_flags_i;
  cps_pkg::cps_core_cmd_t core_cmd_i;
  logic [2:0] reg_idx_i;
  logic [7:0] sfr_rdata_o, stack_top_pointer_o, program_status_word_o, accumulator_o, bank_reg_addr_o;
  logic [15:0] data_pointer_o, op;
  logic [31:0] rnd;
  int n_fail, tests_run;
  cps_cpu_model u_cpu (.core_clk_i(core_clk_i), .op_i(op), .alu_flags_o(alu_flags_i), .core_cmd_o(core_cmd_i));
  cps_core_regs dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i), .alu_flags_i(alu_flags_i),
    .core_cmd_i(core_cmd_i), .reg_idx_i(reg_idx_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
    .stack_top_pointer_o(stack_top_pointer_o), .data_pointer_o(data_pointer_o),
    .program_status_word_o(program_status_word_o), .accumulator_o(accumulator_o), .bank_reg_addr_o(bank_reg_addr_o));
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // request held one full cycle, then a quiet cycle so calls never collide
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    sfr_req_i = '0;
    cyc(1);
  endtask : wr
  task automatic rd(string nm, logic [7:0] a, logic [7:0] e, logic h);
    sfr_req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    sfr_req_i = '0;
    chk(nm, {7'h00, h, e}, {7'h00, sfr_hit_o, sfr_rdata_o});
    cyc(1);
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    rst_i = 1'b1;
    sfr_req_i = '0;
    op = '0;
    reg_idx_i = '0;
    rnd = 32'ha820;
    cyc(3);
    rst_i = 1'b0;
    rd("stack", 8'h81, 8'h07, 1'b1);
    rd("dpl", 8'h82, 8'h00, 1'b1);
    rd("dph", 8'h83, 8'h00, 1'b1);
    rd("psw", 8'hd0, 8'h00, 1'b1);
    rd("acc", 8'he0, 8'h00, 1'b1);
    rd("hole", 8'h97, 8'h00, 1'b0);
    $display("test reset done");
    wr(8'h82, 8'h5a);
    wr(8'h83, 8'ha5);
    chk("data_pointer", 16'ha55a, data_pointer_o);
    // push from the top byte wraps to zero
    wr(8'h81, 8'hff);
    op = 16'h1000;
    cyc(1);
    op = '0;
    cyc(1);
    chk("push", 16'h0000, {8'h00, stack_top_pointer_o});
    // pop from zero wraps back to the top byte
    op = 16'h2000;
    cyc(1);
    op = '0;
    cyc(1);
    chk("pop", 16'h00ff, {8'h00, stack_top_pointer_o});
    // even accumulator, software tries to set the parity bit
    wr(8'he0, 8'h03);
    wr(8'hd0, 8'h01);
    chk("psw_ro", 16'h0000, {8'h00, program_status_word_o});
    for (int b = 0; b < 4; b++)
    begin
      wr(8'hd0, 8'(b << 3));
      reg_idx_i = 3'(2 * b + 1);
      cyc(1);
      chk("bank", 16'(b * 8 + 2 * b + 1), {8'h00, bank_reg_addr_o});
    end
    $display("test pointers done");
    // user flags set, then an add with carries, then one without
    wr(8'hd0, 8'h22);
    op = 16'h88ff;
    cyc(1);
    op = 16'h8000;
    cyc(1);
    op = '0;
    chk("flag_set", 16'h00e6, {8'h00, program_status_word_o});
    cyc(1);
    chk("flag_clr", 16'h0022, {8'h00, program_status_word_o});
    // core loads an odd accumulator; parity and the read path must follow
    op = 16'h4097;
    cyc(1);
    op = '0;
    cyc(1);
    chk("acc_wr", 16'h0097, {8'h00, accumulator_o});
    chk("parity_odd", 16'h0001, {15'h0000, program_status_word_o[0]});
    rd("psw_rd", 8'hd0, 8'h23, 1'b1);
    $display("test flags done");
    for (int i = 0; i < 400; i++)
    begin
      rnd = xs(rnd);
      op = rnd[15:0];
      reg_idx_i = rnd[18:16];
      sfr_req_i = (rnd[31:28] == 4'hf) ? '{1'b1, 1'b0, rnd[27] ? 8'hd0 : 8'h81, rnd[23:16]} : '0;
      cyc(1);
      chk("parity", {15'h0000, ^accumulator_o}, {15'h0000, program_status_word_o[0]});
    end
    sfr_req_i = '0;
    $display("test random done");
    wrap_up();
  end
endmodule : tb
